// *** core/ucf_serial_ctrl.sv ***
// Serial port zero: control register, flags, receiver and transmitter.
// Assumes a single-cycle register port on mclk and an asynchronous rxd line.
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ucf_serial_ctrl #(
   parameter int unsigned MODE0_BIT_CYC = ucf_pkg::MODE0_BIT_CYC,
   parameter int unsigned MODE2_BIT_CYC = ucf_pkg::MODE2_BIT_CYC
) (
   input  wire logic                 mclk,
   input  wire logic                 rst,
   input  wire ucf_pkg::ucf_bus_req_t busReq,
   output logic [7:0]                rdData,
   input  wire logic                 rxd,
   output logic                      txd,
   output logic                      shiftClk,
   output logic                      irq
);

   // Refuse bit times the half-bit sampling cannot serve
   if (MODE0_BIT_CYC < 2 || MODE2_BIT_CYC < 2 || MODE0_BIT_CYC > 4096 || MODE2_BIT_CYC > 4096) begin : g_chk
      $error("ucf_serial_ctrl: bit time parameters out of range");
   end

   ucf_pkg::ucf_state_t s;
   ucf_pkg::ucf_state_t n;

   logic                      rxSet;
   logic                      txSet;
   logic                      rxIn;
   logic                      txStart;
   logic                      accept;
   logic                      addrHit;
   logic [ucf_pkg::TIM_W-1:0] bitLen;
   logic [ucf_pkg::TIM_W-1:0] halfSync;
   logic [3:0]                frameBits;
   logic [10:0]               nextShift;

   // Bit period for the mode in effect; mode 1 and 3 scale with the rate register
   always_comb begin
      bitLen = {1'b0, s.baud, 4'h0} + 13'h0010;
      if (s.ctrl.modeSelect == ucf_pkg::MODE_9FIX) begin
         bitLen = ucf_pkg::TIM_W'(MODE2_BIT_CYC);
      end
      halfSync = ucf_pkg::TIM_W'(MODE0_BIT_CYC / 2);
      frameBits = s.ctrl.modeSelect[1] ? ucf_pkg::FRAME9_BITS : ucf_pkg::FRAME8_BITS;
   end

   always_comb begin
      n = s;
      rxSet = 1'b0;
      txSet = 1'b0;
      accept = 1'b0;
      addrHit = 1'b0;
      nextShift = {1'b1, s.txShift[10:1]};
      rxIn = s.rxSync2;
      txStart = busReq.wr && busReq.addr == ucf_pkg::ADDR_DATA && s.txState == ucf_pkg::TX_IDLE;

      // Two-flop synchroniser plus edge history for rxd
      n.rxSync1 = rxd;
      n.rxSync2 = s.rxSync1;
      n.rxPrev = s.rxSync2;

      // Register writes; hardware effects below override them
      if (busReq.wr) begin
         case (busReq.addr)
            ucf_pkg::ADDR_CTRL:  n.ctrl = busReq.wdata;   // Mode kept as written
            ucf_pkg::ADDR_BAUD:  n.baud = busReq.wdata;
            ucf_pkg::ADDR_OWN:   n.ownAddr = busReq.wdata;
            ucf_pkg::ADDR_BCAST: n.bcastAddr = busReq.wdata;
            ucf_pkg::ADDR_ISTAT: n.intStat = s.intStat & ~busReq.wdata[1:0];
            ucf_pkg::ADDR_IMASK: n.intMask = busReq.wdata[1:0];
            default: ;
         endcase
      end

      // Read data stands only in the cycle after the strobe
      n.rdData = 8'h00;
      if (busReq.rd) begin
         case (busReq.addr)
            ucf_pkg::ADDR_CTRL:  n.rdData = s.ctrl;   // Returns the mode in effect
            ucf_pkg::ADDR_DATA:  n.rdData = s.rxBuf;
            ucf_pkg::ADDR_BAUD:  n.rdData = s.baud;
            ucf_pkg::ADDR_OWN:   n.rdData = s.ownAddr;
            ucf_pkg::ADDR_BCAST: n.rdData = s.bcastAddr;
            ucf_pkg::ADDR_ISTAT: n.rdData = {6'h00, s.intStat};
            ucf_pkg::ADDR_IMASK: n.rdData = {6'h00, s.intMask};
            default:             n.rdData = 8'h00;
         endcase
      end

      // Asynchronous receiver, modes 1 to 3, mid-bit sampling
      case (s.rxState)
         // Line idle; a falling edge opens a frame
         ucf_pkg::RX_IDLE: begin
            if (s.rxPrev && !s.rxSync2) begin
               n.rxState = ucf_pkg::RX_START;
               n.rxTimer = bitLen >> 1;
            end
         end

         // Half a bit on, the start bit is looked at again
         ucf_pkg::RX_START: begin
            if (s.rxTimer == '0) begin
               // A glitch shorter than half a bit is dropped
               n.rxState = rxIn ? ucf_pkg::RX_IDLE : ucf_pkg::RX_DATA;
               n.rxTimer = bitLen - 13'h0001;
               n.rxCnt = 3'h0;
            end else begin
               n.rxTimer = s.rxTimer - 13'h0001;
            end
         end

         // Eight data bits, least significant first
         ucf_pkg::RX_DATA: begin
            if (s.rxTimer == '0) begin
               n.rxShift = {rxIn, s.rxShift[7:1]};
               n.rxTimer = bitLen - 13'h0001;
               n.rxCnt = s.rxCnt + 3'h1;
               if (s.rxCnt == 3'h7) begin
                  n.rxState = s.ctrl.modeSelect[1] ? ucf_pkg::RX_NINTH : ucf_pkg::RX_STOP;
               end
            end else begin
               n.rxTimer = s.rxTimer - 13'h0001;
            end
         end

         // Nine-bit modes only: keep the extra bit
         ucf_pkg::RX_NINTH: begin
            if (s.rxTimer == '0) begin
               n.rxNinth = rxIn;
               n.rxTimer = bitLen - 13'h0001;
               n.rxState = ucf_pkg::RX_STOP;
            end else begin
               n.rxTimer = s.rxTimer - 13'h0001;
            end
         end

         // Mid stop bit: acceptance and the ninth-bit field
         ucf_pkg::RX_STOP: begin
            if (s.rxTimer == '0) begin
               n.rxState = ucf_pkg::RX_IDLE;
               // Own and broadcast addresses both count as a hit
               addrHit = s.rxShift == s.ownAddr || s.rxShift == s.bcastAddr;
               if (s.ctrl.modeSelect[1]) begin
                  n.ctrl.rxNinthBit = s.rxNinth;
                  accept = !s.ctrl.multiprocEnable
                        || (s.rxNinth && addrHit);
               end else begin
                  if (!s.ctrl.multiprocEnable) begin
                     n.ctrl.rxNinthBit = rxIn;
                  end
                  accept = !s.ctrl.multiprocEnable || rxIn;
               end
               // Only an accepted byte overwrites the buffer
               if (accept) begin
                  n.rxBuf = s.rxShift;
                  rxSet = 1'b1;
               end
            end else begin
               n.rxTimer = s.rxTimer - 13'h0001;
            end
         end

         // Unused codes recover to idle
         default: n.rxState = ucf_pkg::RX_IDLE;
      endcase
      // Receiver held off when disabled or in shift mode
      if (!s.ctrl.receiverEnable || s.ctrl.modeSelect == ucf_pkg::MODE_SYNC) begin
         n.rxState = ucf_pkg::RX_IDLE;
      end

      // Transmitter, also the clock engine for shift-mode reception
      case (s.txState)
         // Idle: a data write or shift-mode reception starts work
         ucf_pkg::TX_IDLE: begin
            n.txd = 1'b1;
            n.shiftClk = 1'b1;
            if (txStart && s.ctrl.modeSelect == ucf_pkg::MODE_SYNC) begin
               n.txState = ucf_pkg::TX_SYNC;
               n.txShift = {3'h7, busReq.wdata};
               n.txd = busReq.wdata[0];
               n.shiftClk = 1'b0;
               n.txTimer = halfSync - 13'h0001;
               n.txCnt = 4'h0;
               n.txPhase = 1'b0;
               n.m0Rx = 1'b0;
            end else if (txStart) begin
               // Ninth bit only exists in nine-bit frames; mode 1 sees a stop there
               n.txShift = {1'b1, s.ctrl.modeSelect[1] ? s.ctrl.txNinthBit : 1'b1,
                            busReq.wdata, 1'b0};
               n.txState = ucf_pkg::TX_ASYNC;
               n.txd = 1'b0;
               n.txTimer = bitLen - 13'h0001;
               n.txCnt = 4'h0;
            end else if (s.ctrl.modeSelect == ucf_pkg::MODE_SYNC && s.ctrl.receiverEnable
                         && !s.ctrl.rxDoneFlag) begin
               n.txState = ucf_pkg::TX_SYNC;
               n.shiftClk = 1'b0;
               n.txTimer = halfSync - 13'h0001;
               n.txCnt = 4'h0;
               n.txPhase = 1'b0;
               n.m0Rx = 1'b1;
            end
         end

         // Asynchronous frame, one shift per bit period
         ucf_pkg::TX_ASYNC: begin
            if (s.txTimer == '0) begin
               n.txTimer = bitLen - 13'h0001;
               n.txCnt = s.txCnt + 4'h1;
               n.txShift = nextShift;
               n.txd = nextShift[0];
               if (s.txCnt + 4'h1 == frameBits - 4'h1) begin
                  txSet = 1'b1;
               end
               if (s.txCnt == frameBits - 4'h1) begin
                  n.txState = ucf_pkg::TX_IDLE;
                  n.txd = 1'b1;
               end
            end else begin
               n.txTimer = s.txTimer - 13'h0001;
            end
         end

         // Shift mode: low half then high half of each bit
         ucf_pkg::TX_SYNC: begin
            if (s.txTimer == '0) begin
               n.txTimer = halfSync - 13'h0001;
               n.txPhase = !s.txPhase;
               if (!s.txPhase) begin
                  // Rising shift clock: peer data is sampled here
                  n.shiftClk = 1'b1;
                  if (s.m0Rx) begin
                     n.txShift = {s.txShift[10:8], rxIn, s.txShift[7:1]};
                  end
               end else begin
                  n.shiftClk = 1'b0;
                  n.txCnt = s.txCnt + 4'h1;
                  if (!s.m0Rx) begin
                     n.txShift = nextShift;
                     n.txd = nextShift[0];
                  end
                  if (s.txCnt == 4'h7) begin
                     n.txState = ucf_pkg::TX_IDLE;
                     n.shiftClk = 1'b1;
                     n.txd = 1'b1;
                     if (s.m0Rx) begin
                        n.rxBuf = s.txShift[7:0];
                        rxSet = 1'b1;          // No ninth-bit update in shift mode
                     end else begin
                        txSet = 1'b1;          // After the eighth bit
                     end
                  end
               end
            end else begin
               n.txTimer = s.txTimer - 13'h0001;
            end
            // Dropping receive enable ends a shift-mode reception at once
            if (s.m0Rx && !s.ctrl.receiverEnable) begin
               n.txState = ucf_pkg::TX_IDLE;
               n.shiftClk = 1'b1;
            end
         end

         // Unused codes recover to idle
         default: n.txState = ucf_pkg::TX_IDLE;
      endcase

      // Flags: hardware set wins over a software clear in the same cycle
      if (rxSet) begin
         n.ctrl.rxDoneFlag = 1'b1;
         n.intStat[ucf_pkg::IRQ_RX] = 1'b1;
      end
      if (txSet) begin
         n.ctrl.txDoneFlag = 1'b1;
         n.intStat[ucf_pkg::IRQ_TX] = 1'b1;
      end
   end

   // Single state register; reset values all constant
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.ctrl <= ucf_pkg::CTRL_RST;
         s.baud <= ucf_pkg::BAUD_RST;
         s.ownAddr <= ucf_pkg::OWN_RST;
         s.bcastAddr <= ucf_pkg::BCAST_RST;
         s.intMask <= ucf_pkg::IMASK_RST;
         // Line history starts at mark level, so no false edge after reset
         s.rxSync1 <= 1'b1;
         s.rxSync2 <= 1'b1;
         s.rxPrev <= 1'b1;
         s.txd <= 1'b1;
         s.shiftClk <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // Outputs straight from the state register except irq, gated by the mask
   assign rdData = s.rdData;
   assign txd = s.txd;
   assign shiftClk = s.shiftClk;
   assign irq = |(s.intStat & s.intMask);   // Level, follows unmasked sticky bits

endmodule
`default_nettype wire

// *** pkg/ucf_pkg.sv ***
// Constants, field layouts and state types for the serial port control block.
// Assumes an 8-bit register port with a 3-bit byte address and a 100 MHz mclk.
// What this block does
// - Multiprocessor enable meaning follows mode; mode 0 ignores.
// - Mode 1, enable set: flag only on high stop.
// - Modes 2/3, enable clear: ninth bit ignored.
// - Modes 2/3, enable set: ninth=1 and address match.
// - Receive enable on starts receiver, off stops it.
// - Modes 2/3 send software ninth bit; else unused.
// - Modes 2/3 capture received ninth bit each frame.
// - Mode 1, enable clear: store stop bit; mode 0 not.
// - Accepted byte sets receive flag and status; interrupt only if unmasked.
package ucf_pkg;

   // Clock and bit timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int MODE0_BIT_NS  = 120;
   localparam int MODE2_BIT_NS  = 640;
   localparam int MODE0_BIT_CYC = (MODE0_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MODE2_BIT_CYC = (MODE2_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIM_W         = 13;

   // Register byte addresses
   localparam logic [2:0] ADDR_CTRL  = 3'h0;
   localparam logic [2:0] ADDR_DATA  = 3'h1;
   localparam logic [2:0] ADDR_BAUD  = 3'h2;
   localparam logic [2:0] ADDR_OWN   = 3'h3;
   localparam logic [2:0] ADDR_BCAST = 3'h4;
   localparam logic [2:0] ADDR_ISTAT = 3'h5;
   localparam logic [2:0] ADDR_IMASK = 3'h6;

   // Operating modes in the mode field
   localparam logic [1:0] MODE_SYNC = 2'h0;
   localparam logic [1:0] MODE_8VAR = 2'h1;
   localparam logic [1:0] MODE_9FIX = 2'h2;
   localparam logic [1:0] MODE_9VAR = 2'h3;

   // Interrupt status and mask bit positions
   localparam int IRQ_RX = 0;
   localparam int IRQ_TX = 1;

   // Frame lengths in bit times, stop bit included
   localparam logic [3:0] FRAME8_BITS = 4'ha;
   localparam logic [3:0] FRAME9_BITS = 4'hb;

   // Reset values
   localparam logic [7:0] CTRL_RST  = 8'h00;
   localparam logic [7:0] BAUD_RST  = 8'h00;
   localparam logic [7:0] OWN_RST   = 8'h00;
   localparam logic [7:0] BCAST_RST = 8'hff;
   localparam logic [1:0] IMASK_RST = 2'h0;

   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} ucf_rx_state_t;
   typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} ucf_tx_state_t;

   // Register port request
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ucf_bus_req_t;

   // Serial port control register, bit 7 first
   typedef struct packed {
      logic [1:0] modeSelect;   // mode_select_hi, mode_select_lo
      logic       multiprocEnable;
      logic       receiverEnable;
      logic       txNinthBit;
      logic       rxNinthBit;
      logic       txDoneFlag;
      logic       rxDoneFlag;
   } ucf_ctrl_t;

   // Whole state of the block
   typedef struct packed {
      ucf_ctrl_t          ctrl;
      logic [7:0]         rxBuf;
      logic [7:0]         baud;
      logic [7:0]         ownAddr;
      logic [7:0]         bcastAddr;
      logic [1:0]         intStat;
      logic [1:0]         intMask;
      logic [7:0]         rdData;
      logic               rxSync1;
      logic               rxSync2;
      logic               rxPrev;
      ucf_rx_state_t      rxState;
      logic [TIM_W-1:0]   rxTimer;
      logic [2:0]         rxCnt;
      logic [7:0]         rxShift;
      logic               rxNinth;
      ucf_tx_state_t      txState;
      logic [TIM_W-1:0]   txTimer;
      logic [3:0]         txCnt;
      logic [10:0]        txShift;
      logic               txPhase;
      logic               m0Rx;
      logic               txd;
      logic               shiftClk;
   } ucf_state_t;

endpackage

// *** testbench/ucf_peer_model.sv ***
// Serial peer on the line side: sends frames on rxd and captures txd.
// Assumes the caller gives bit times in mclk cycles.
`timescale 1ns/1ps
`default_nettype none
module ucf_peer_model (
   input  wire logic mclk,
   input  wire logic txd,
   output logic      rxd
);
   // Mark level between frames, as a pulled-up line shows
   initial rxd = 1'b1;
   // Start, data LSB first, ninth or stop bit, then mark
   task automatic sendFrame(input logic [7:0] d, input logic b9, input int bc);
      logic [10:0] f;
      f = {1'b1, b9, d, 1'b0}; // Ninth bit rides here
      for (int i = 0; i < 11; i++) begin
         @(posedge mclk);
         rxd <= f[i];
         repeat (bc - 1) @(posedge mclk);
      end
   endtask
   // Mid-bit sampling is safe since txd only moves at bit edges
   task automatic getFrame(input int bc, output logic [10:0] f);
      @(negedge txd);
      repeat (bc / 2) @(posedge mclk);
      for (int i = 0; i < 11; i++) begin
         f[i] = txd;
         repeat (bc) @(posedge mclk);
      end
   endtask
endmodule
`default_nettype wire

// *** testbench/ucf_serial_ctrl_bench.sv ***
// Self-checking bench for the serial port control block.
// Assumes the peer model on the line and the checker bound by its own file.
`timescale 1ns/1ps
`default_nettype none
module ucf_serial_ctrl_bench;
   typedef struct packed {
      logic [1:0] mode;
      logic       mpe;
      logic       ren;
      logic       ninth;
      logic [7:0] data;
      logic       acc;
      logic       rx9;
   } ucf_row_t;
   logic                  mclk = 1'b0;
   logic                  rst = 1'b1;
   ucf_pkg::ucf_bus_req_t busReq = '0;
   logic [7:0]            rdData;
   logic                  txd;
   logic                  shiftClk;
   logic                  irq;
   logic                  rxd;
   logic [7:0]            v;
   logic [10:0]           bits;
   ucf_row_t              r;
   int                    nErrors = 0;
   int                    nChecks = 0;
   logic [2:0]            resA [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
   logic [7:0]            resV [5] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
   // Mode, mpe, ren, ninth or stop, byte, accepted, ninth-bit field
   ucf_row_t              rows [11] = '{
      '{2'h1, 1'b0, 1'b1, 1'b1, 8'h3c, 1'b1, 1'b1}, '{2'h1, 1'b0, 1'b1, 1'b0, 8'h3c, 1'b1, 1'b0},
      '{2'h1, 1'b1, 1'b1, 1'b0, 8'hc3, 1'b0, 1'b0}, '{2'h1, 1'b1, 1'b1, 1'b1, 8'hc3, 1'b1, 1'b0},
      '{2'h2, 1'b0, 1'b1, 1'b0, 8'h33, 1'b1, 1'b0}, '{2'h2, 1'b1, 1'b1, 1'b1, 8'h33, 1'b0, 1'b1},
      '{2'h2, 1'b1, 1'b1, 1'b0, 8'h5a, 1'b0, 1'b0}, '{2'h2, 1'b1, 1'b1, 1'b1, 8'h5a, 1'b1, 1'b1},
      '{2'h3, 1'b1, 1'b1, 1'b1, 8'hff, 1'b1, 1'b1}, '{2'h3, 1'b0, 1'b1, 1'b1, 8'h11, 1'b1, 1'b1},
      '{2'h2, 1'b0, 1'b0, 1'b0, 8'h44, 1'b0, 1'b0}};
   // Short mode 0 and mode 2 bit times keep the run brief
   ucf_serial_ctrl #(.MODE0_BIT_CYC(4), .MODE2_BIT_CYC(8)) DUT (.mclk(mclk), .rst(rst), .busReq(busReq),
      .rdData(rdData), .rxd(rxd), .txd(txd), .shiftClk(shiftClk), .irq(irq));
   ucf_peer_model peer (.mclk(mclk), .txd(txd), .rxd(rxd));
   // 100 MHz clock
   always #5 mclk = ~mclk;
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      busReq.wr <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge mclk);
      busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      busReq.rd <= 1'b0;
      #1 d = rdData;
   endtask
   task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
      nChecks++;
      if (seen !== exp) begin
         nErrors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic endOfTest;
      $display("checks %0d, mismatches %0d", nChecks, nErrors);
      if (nErrors == 0 && nChecks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Mode 1 would show a zero ninth bit in place of its stop bit if misused
   task automatic txCase(input logic [1:0] m, input logic t8, input logic [7:0] d);
      int bc;
      logic [10:0] e;
      bc = (m == ucf_pkg::MODE_9FIX) ? 8 : 16;
      e = (m == ucf_pkg::MODE_8VAR) ? {2'b11, d, 1'b0} : {1'b1, t8, d, 1'b0};
      wr(ucf_pkg::ADDR_CTRL, {m, 2'b00, t8, 3'b000});
      fork
         peer.getFrame(bc, bits);
         wr(ucf_pkg::ADDR_DATA, d);
      join
      chk(bits, e); // Line bits
      rd(ucf_pkg::ADDR_CTRL, v);
      chk(11'(v), 11'({m, 2'b00, t8, 3'b010})); // Done set, mode kept
      wr(ucf_pkg::ADDR_CTRL, 8'h00);
      rd(ucf_pkg::ADDR_CTRL, v);
      chk(11'(v), 11'h000); // Cleared by software
      $display("transmit mode %0d done", m);
   endtask
   // Watchdog well above the expected few thousand cycles
   initial begin
      repeat (20000) @(posedge mclk);
      nErrors++;
      endOfTest;
   end
   // Main sequence
   initial begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      wr(3'h7, 8'h5a);
      foreach (resA[i]) begin
         rd(resA[i], v);
         chk(11'(v), 11'(resV[i])); // Reset values
      end
      $display("reset test done");
      wr(ucf_pkg::ADDR_OWN, 8'h5a);
      wr(ucf_pkg::ADDR_IMASK, 8'h01);
      foreach (rows[i]) begin
         r = rows[i];
         wr(ucf_pkg::ADDR_CTRL, {r.mode, r.mpe, r.ren, 4'h0});
         peer.sendFrame(r.data, r.ninth, (r.mode == ucf_pkg::MODE_9FIX) ? 8 : 16);
         repeat (8) @(posedge mclk);
         rd(ucf_pkg::ADDR_CTRL, v);
         chk(11'(v), 11'({r.mode, r.mpe, r.ren, 1'b0, r.rx9, 1'b0, r.acc}));
         chk(11'(irq), 11'(r.acc)); // Interrupt
         rd(ucf_pkg::ADDR_DATA, v);
         if (r.acc) begin
            chk(11'(v), 11'(r.data)); // Byte kept
         end
         wr(ucf_pkg::ADDR_ISTAT, 8'h01);
         wr(ucf_pkg::ADDR_CTRL, 8'h00);
      end
      $display("receive table done");
      txCase(ucf_pkg::MODE_8VAR, 1'b0, 8'ha5);
      txCase(ucf_pkg::MODE_9FIX, 1'b1, 8'h3c);
      txCase(ucf_pkg::MODE_9VAR, 1'b0, 8'hc3);
      // Transmit status is pending but masked, then unmasked, then cleared
      #1;
      chk(11'(irq), 11'h000); // Masked
      wr(ucf_pkg::ADDR_IMASK, 8'h03);
      #1;
      chk(11'(irq), 11'h001); // Unmasked
      wr(ucf_pkg::ADDR_ISTAT, 8'h02);
      #1;
      chk(11'(irq), 11'h000); // Cleared
      $display("interrupt test done");
      // Mode 0 reception with mpe set must still flag the byte
      wr(ucf_pkg::ADDR_CTRL, 8'h30);
      repeat (60) @(posedge mclk);
      rd(ucf_pkg::ADDR_DATA, v);
      chk(11'(v), 11'h0ff); // Shifted
      rd(ucf_pkg::ADDR_CTRL, v);
      chk(11'(v), 11'h031); // Flag despite mpe
      $display("mode 0 test done");
      // Mode 0 send: bits taken at each rising shift clock, ninth-bit field set but unused
      wr(ucf_pkg::ADDR_CTRL, 8'h08);
      fork
         for (int i = 0; i < 8; i++) begin
            @(posedge shiftClk);
            #1 bits[i] = txd;
         end
         wr(ucf_pkg::ADDR_DATA, 8'h96);
      join
      repeat (8) @(posedge mclk);
      chk(11'(bits[7:0]), 11'h096); // Shifted out LSB first
      rd(ucf_pkg::ADDR_CTRL, v);
      chk(11'(v), 11'h00a); // Done after the eighth bit
      #1;
      chk(11'(irq), 11'h001); // Pending before reset
      $display("mode 0 send done");
      // Reset in mid-run with an interrupt pending
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      chk(11'({rdData, txd, shiftClk, irq}), 11'h006); // Outputs at rest
      @(posedge mclk);
      rst <= 1'b0;
      foreach (resA[i]) begin
         rd(resA[i], v);
         chk(11'(v), 11'(resV[i])); // Reset values again
      end
      $display("mid-run reset test done");
      endOfTest;
   end
endmodule
`default_nettype wire

// *** testbench/ucf_serial_ctrl_props.sv ***
// Checker for the serial port control block, watching only its top ports.
// Assumes the map of ucf_pkg and a bus that never strobes both ways at once.
`timescale 1ns/1ps
`default_nettype none
module ucf_serial_ctrl_props (
   input wire logic                  mclk,
   input wire logic                  rst,
   input wire ucf_pkg::ucf_bus_req_t busReq,
   input wire logic [7:0]            rdData,
   input wire logic                  txd,
   input wire logic                  shiftClk,
   input wire logic                  irq
);
   logic [7:0] ctrlSh;
   logic [7:0] lastCtrl;
   logic [1:0] maskSh;
   logic [1:0] seen;
   logic       rdCtrlD;
   logic       txArmed;
   logic       m0Act;
   logic       wrCtrl;
   logic       wrData;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Decoded writes
   assign wrCtrl = busReq.wr && busReq.addr == ucf_pkg::ADDR_CTRL;
   assign wrData = busReq.wr && busReq.addr == ucf_pkg::ADDR_DATA;
   // Shadows of software writes; flags once seen set stay set until written low
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrlSh   <= 8'h00;
         lastCtrl <= 8'h00;
         maskSh   <= 2'h0;
         seen     <= 2'h0;
         rdCtrlD  <= 1'b0;
         txArmed  <= 1'b0;
         m0Act    <= 1'b0;
      end else begin
         rdCtrlD <= busReq.rd && busReq.addr == ucf_pkg::ADDR_CTRL;
         if (busReq.rd && busReq.addr == ucf_pkg::ADDR_CTRL) begin
            lastCtrl <= ctrlSh;
         end
         seen <= (seen | (rdCtrlD ? rdData[1:0] : 2'h0)) & (wrCtrl ? busReq.wdata[1:0] : 2'h3);
         if (wrCtrl) begin
            ctrlSh <= busReq.wdata;
         end
         if (busReq.wr && busReq.addr == ucf_pkg::ADDR_IMASK) begin
            maskSh <= busReq.wdata[1:0];
         end
         if (wrData) begin
            txArmed <= 1'b1;
         end
         // Shift engine may only wake in mode 0 with reception on, or on a send
         if ((wrCtrl && busReq.wdata[7:6] == ucf_pkg::MODE_SYNC && busReq.wdata[4]) ||
             (wrData && ctrlSh[7:6] == ucf_pkg::MODE_SYNC)) begin
            m0Act <= 1'b1;
         end
      end
   end
   sequence s_firstWr;
      wrData && !txArmed && ctrlSh[7:6] != ucf_pkg::MODE_SYNC;
   endsequence
   sequence s_startBit;
      !txd ##1 !txd;
   endsequence
   property p_rdIdle;
      !busReq.rd |=> rdData == 8'h00;
   endproperty
   property p_rdUnmapped;
      busReq.rd && busReq.addr == 3'h7 |=> rdData == 8'h00;
   endproperty
   property p_ctrlRead;
      busReq.rd && busReq.addr == ucf_pkg::ADDR_CTRL |=> rdData[7:3] == lastCtrl[7:3];
   endproperty
   property p_doneSticky;
      rdCtrlD |-> (rdData[1:0] & seen) == seen;
   endproperty
   property p_irqMask;
      irq |-> maskSh != 2'h0;
   endproperty
   property p_txIdle;
      !txArmed |-> txd;
   endproperty
   property p_shiftIdle;
      !m0Act |-> shiftClk;
   endproperty
   property p_firstTx;
      s_firstWr |=> s_startBit;
   endproperty
   a_rdIdle: assert property (p_rdIdle) else $error("read data not zero when idle");
   a_rdUnmapped: assert property (p_rdUnmapped) else $error("unmapped read not zero");
   a_ctrlRead: assert property (p_ctrlRead) else $error("control readback wrong");
   a_doneSticky: assert property (p_doneSticky) else $error("done flag lost");
   a_irqMask: assert property (p_irqMask) else $error("interrupt while masked");
   a_txIdle: assert property (p_txIdle) else $error("txd left idle early");
   a_shiftIdle: assert property (p_shiftIdle) else $error("shift clock moved");
   a_firstTx: assert property (p_firstTx) else $error("no start bit");
endmodule
bind ucf_serial_ctrl ucf_serial_ctrl_props u_props (.mclk(mclk), .rst(rst), .busReq(busReq),
   .rdData(rdData), .txd(txd), .shiftClk(shiftClk), .irq(irq));
`default_nettype wire
